// file: stepper_setup_pkg.sv
package stepper_setup_pkg;

  localparam int FRAME_BYTES = 13;
  localparam int BYTE_W      = 8;

  // Byte positions inside the frame, counted from zero.
  localparam int IDX_FIRST_WAIT = 0;
  localparam int IDX_MAG_WAIT   = 1;
  localparam int IDX_CHOP_EXP   = 2;
  localparam int IDX_MON_POWER  = 3;
  localparam int IDX_DRIVE      = 4;
  localparam int IDX_COUNT      = 5;
  localparam int IDX_PERIOD_LO  = 6;
  localparam int IDX_PERIOD_HI  = 7;

  // Field layout of the chop and expander byte.
  localparam int CHOP_LSB = 0;
  localparam int CHOP_W   = 6;
  localparam int EXPANDER_OUT_ZERO_BIT = 6;
  localparam int EXPANDER_OUT_ONE_BIT = 7;

  // Field layout of the monitor select and power byte.
  localparam int MON_SEL_W = 7;
  localparam int POWER_BIT = 7;
  localparam int SEL_ENABLE  = 6;
  localparam int SEL_DIR     = 5;
  localparam int SEL_PULSE   = 4;
  localparam int SEL_PRESENT = 3;
  localparam int SEL_GATE    = 2;
  localparam int SEL_CHECK   = 1;
  localparam int SEL_CHOP    = 0;

  // Field layout of the first channel drive byte.
  localparam int ENABLE_BIT  = 7;
  localparam int DIR_BIT     = 6;
  localparam int CUR_LSB     = 0;
  localparam int CUR_W       = 5;
  localparam logic [CUR_W-1:0] CUR_CLAMP_MAX = 5'h0a;
  localparam logic [CUR_W-1:0] CUR_MIN_VALID = 5'h0b;

  // Timing in reference clock periods.
  localparam int REF_TICKS_PER_STEP = 1024;
  localparam int WAIT_SHIFT         = $clog2(REF_TICKS_PER_STEP);
  localparam int WAIT_CNT_W         = BYTE_W + WAIT_SHIFT;
  localparam int PULSES_PER_COUNT   = 4;
  localparam int PULSE_SHIFT        = $clog2(PULSES_PER_COUNT);
  localparam int PULSE_CNT_W        = BYTE_W + PULSE_SHIFT;
  localparam int PERIOD_W           = 2 * BYTE_W;
  localparam logic [WAIT_SHIFT-1:0]  WAIT_PAD  = '0;
  localparam logic [PULSE_SHIFT-1:0] PULSE_PAD = '0;
  localparam logic [WAIT_CNT_W-1:0]  WAIT_ONE  = 18'h00001;
  localparam logic [PULSE_CNT_W-1:0] PULSE_ONE = 10'h001;
  localparam logic [PERIOD_W-1:0]    PERIOD_ONE = 16'h0001;
  localparam logic [CHOP_W-1:0]      CHOP_ONE  = 6'h01;

  // Reset values of the held settings.
  localparam logic [1:0]           RST_EXP       = 2'h3;
  localparam logic [MON_SEL_W-1:0] RST_MON_SEL   = 7'h00;
  localparam logic [BYTE_W-1:0]    RST_WAIT      = 8'h01;
  localparam logic [CHOP_W-1:0]    RST_CHOP      = 6'h00;
  localparam logic [CUR_W-1:0]     RST_CUR       = 5'h0b;
  localparam logic [BYTE_W-1:0]    RST_COUNT     = 8'h00;
  localparam logic [PERIOD_W-1:0]  RST_PERIOD    = 16'h0001;

  typedef enum logic [4:0] {
    PH_IDLE  = 5'b00001,
    PH_FIRST = 5'b00010,
    PH_MAG   = 5'b00100,
    PH_PULSE = 5'b01000,
    PH_SAVE  = 5'b10000
  } phase_t;

endpackage : stepper_setup_pkg

// file: frame_store_if.sv
`timescale 1ns/1ps
`default_nettype none
interface frame_store_if;
  import stepper_setup_pkg::*;
  logic              bit_valid;
  logic              bit_data;
  logic              clear;
  logic [BYTE_W-1:0] byte_q [FRAME_BYTES];
  logic              sum_zero;
  logic              frame_full;

  modport store (input bit_valid, input bit_data, input clear,
                 output byte_q, output sum_zero, output frame_full);
  modport user  (output bit_valid, output bit_data, output clear,
                 input byte_q, input sum_zero, input frame_full);
endinterface : frame_store_if
`default_nettype wire

// file: frame_byte_store.sv
`timescale 1ns/1ps
`default_nettype none
module frame_byte_store
  import stepper_setup_pkg::*;
#(
  parameter int BYTES = FRAME_BYTES
)
(
  input  wire logic    mclk,
  input  wire logic    reset_n,
  frame_store_if.store bus
);
  localparam logic [3:0] BYTES_L = 4'(BYTES);

  logic [2:0]        bit_idx_q;
  logic [3:0]        byte_idx_q;
  logic [BYTE_W-1:0] shift_q;
  logic [BYTE_W-1:0] sum_q;
  logic [BYTE_W-1:0] mem_q [BYTES];

  // Bits arrive least significant first, so each new bit enters at the top.
  wire  [BYTE_W-1:0] shift_d   = {bus.bit_data, shift_q[BYTE_W-1:1]};
  wire               not_full  = (byte_idx_q != BYTES_L);
  wire               take_bit  = bus.bit_valid && not_full;
  wire               byte_done = take_bit && (bit_idx_q == 3'h7);

  always_ff @(posedge mclk)
  begin
    if (!reset_n || bus.clear)
    begin
      bit_idx_q  <= 3'h0;
      byte_idx_q <= 4'h0;
      shift_q    <= 8'h00;
      sum_q      <= 8'h00;
    end
    else if (take_bit)
    begin
      shift_q   <= shift_d;
      bit_idx_q <= bit_idx_q + 3'h1;
      if (byte_done)
      begin
        byte_idx_q <= byte_idx_q + 4'h1;
        sum_q      <= sum_q + shift_d;
      end
    end
  end

  // Storage keeps no reset; the user only reads it once a frame is full.
  always_ff @(posedge mclk)
  begin
    if (byte_done)
    begin
      mem_q[byte_idx_q] <= shift_d;
    end
  end

  assign bus.byte_q     = mem_q;
  assign bus.sum_zero   = (sum_q == 8'h00);
  assign bus.frame_full = !not_full;

endmodule : frame_byte_store
`default_nettype wire

// file: stepper_serial_setup_decoder.sv
// Summary of operation
// - Magnetize wait starts when first wait ends; lasts byte times 1024 reference periods.
// - A zero magnetize-wait byte is forbidden; such a frame is never latched.
// - Chopping frequency code comes from bits 0 to 5 of the third byte.
// - Expander bit 0 sinks its pin low; bit 1 leaves it floating.
// - Fourth byte bits 0 to 6 select monitor signals, one monitor per channel.
// - Select bits map enable, direction, pulse, present, gate, checksum/wait, chop/wait.
// - Several selected signals on one monitor are ORed together.
// - First wait flag spans first wait; combined flag spans both wait intervals.
// - Present flag shows pulses requested; gate flag shows pulses being generated.
// - Checksum status is high after a good frame, low after a bad one.
// - Fourth byte bit 7 high means normal mode, low means power save.
// - Fifth byte bit 7 low floats the bridge while counters keep running.
// - Fifth byte bit 6 low steps forward, high steps in reverse.
// - Fifth byte bit 5 is sent as zero and ignored here.
// - Fifth byte bits 0 to 4 feed the current reference converter.
// - Current codes up to ten are clamped to the lowest valid code.
// - Sixth byte times four gives the pulse count per frame period.
// - Pulses start only after both waits end, and stop at the next frame.
// - A nonzero byte sum inhibits stepping and drives checksum status low.
`timescale 1ns/1ps
`default_nettype none
module stepper_serial_setup_decoder
  import stepper_setup_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             reset_n,
  input  wire logic             serial_clk,
  input  wire logic             serial_data,
  input  wire logic             latch_in,
  input  wire logic             frame_sync,
  input  wire logic             ref_clk,
  input  wire logic [4:0]       second_channel_status,
  output logic                  expander_out_zero,
  output logic                  expander_out_zero_oe,
  output logic                  expander_out_one,
  output logic                  expander_out_one_oe,
  output logic                  first_channel_monitor,
  output logic                  second_channel_monitor,
  output logic                  first_channel_step,
  output logic                  first_channel_dir,
  output logic                  first_channel_bridge_on,
  output logic [CUR_W-1:0]      current_reference_setting,
  output logic [CHOP_W-1:0]     chop_frequency_code,
  output logic                  chop_wave,
  output logic                  power_save,
  output logic                  checksum_status,
  output logic                  first_wait_flag,
  output logic                  combined_wait_flag,
  output logic                  pulse_gate_flag,
  output logic                  pulse_present_flag
);

  frame_store_if fs_if ();

  frame_byte_store #(
    .BYTES (FRAME_BYTES)
  ) u_store (
    .mclk    (mclk),
    .reset_n (reset_n),
    .bus     (fs_if.store)
  );

  logic                   sclk_prev_q;
  logic                   latch_prev_q;
  logic                   vd_prev_q;
  logic                   ref_prev_q;
  logic [1:0]             exp_q;
  logic [MON_SEL_W-1:0]   mon_sel_q;
  logic                   normal_mode_q;
  logic                   ps_hold_q;
  logic [CHOP_W-1:0]      chop_code_q;
  logic [CHOP_W-1:0]      chop_cnt_q;
  logic                   chop_q;
  logic                   enable_q;
  logic                   dir_q;
  logic [CUR_W-1:0]       cur_q;
  logic [BYTE_W-1:0]      pcount_q;
  logic [PERIOD_W-1:0]    period_q;
  logic [BYTE_W-1:0]      wait_pend_q;
  logic [BYTE_W-1:0]      mag_pend_q;
  logic                   checksum_q;
  phase_t                 phase_q;
  phase_t                 phase_d;
  logic [WAIT_CNT_W-1:0]  wait_cnt_q;
  logic [WAIT_CNT_W-1:0]  wait_cnt_d;
  logic [PERIOD_W-1:0]    per_cnt_q;
  logic [PERIOD_W-1:0]    per_cnt_d;
  logic [PULSE_CNT_W-1:0] remain_q;
  logic [PULSE_CNT_W-1:0] remain_d;
  logic                   step_q;
  logic                   step_d;
  logic                   ff1_fall;

  wire serial_rise = serial_clk && !sclk_prev_q;
  wire latch_fall  = !latch_in && latch_prev_q;
  wire vd_rise     = frame_sync && !vd_prev_q;
  wire ref_tick    = ref_clk && !ref_prev_q;

  // Bits enter the store least significant first.
  assign fs_if.bit_valid = serial_rise;
  assign fs_if.bit_data  = serial_data;
  assign fs_if.clear     = latch_fall;

  wire [BYTE_W-1:0] b_first  = fs_if.byte_q[IDX_FIRST_WAIT];
  wire [BYTE_W-1:0] b_mag    = fs_if.byte_q[IDX_MAG_WAIT];
  wire [BYTE_W-1:0] b_chop   = fs_if.byte_q[IDX_CHOP_EXP];
  wire [BYTE_W-1:0] b_mon    = fs_if.byte_q[IDX_MON_POWER];
  wire [BYTE_W-1:0] b_drive  = fs_if.byte_q[IDX_DRIVE];
  wire [BYTE_W-1:0] b_count  = fs_if.byte_q[IDX_COUNT];
  wire [PERIOD_W-1:0] b_period = {fs_if.byte_q[IDX_PERIOD_HI],
                                  fs_if.byte_q[IDX_PERIOD_LO]};

  wire frame_good   = fs_if.frame_full && fs_if.sum_zero;
  // Either wait byte at zero would wrap its wait counter and stall the wait sequence, so such frames are dropped.
  wire frame_accept = latch_fall && frame_good
                      && (b_mag != 8'h00) && (b_first != 8'h00);
  wire period_valid = (b_period != 16'h0000);

  wire [CUR_W-1:0] cur_raw   = b_drive[CUR_LSB +: CUR_W];
  wire [CUR_W-1:0] cur_clamp = (cur_raw <= CUR_CLAMP_MAX) ? CUR_MIN_VALID
                                                          : cur_raw;

  wire chop_run  = normal_mode_q && (chop_code_q != 6'h00);
  wire chop_wrap = (chop_cnt_q >= chop_code_q - CHOP_ONE);

  wire ff1_now   = (phase_q == PH_FIRST) || (phase_q == PH_SAVE);
  wire ff2_now   = (phase_q == PH_FIRST) || (phase_q == PH_MAG);
  // The gate stays open until the last step pulse has ended, not only while counting.
  wire gate_now  = (phase_q == PH_PULSE) || step_q;
  wire pres_now  = (pcount_q != 8'h00);
  wire bridge_now = enable_q && normal_mode_q && !ps_hold_q;

  wire [MON_SEL_W-1:0] first_sources;
  wire [MON_SEL_W-1:0] second_sources;
  assign first_sources[SEL_ENABLE]   = bridge_now;
  assign first_sources[SEL_DIR]      = dir_q;
  assign first_sources[SEL_PULSE]    = step_q;
  assign first_sources[SEL_PRESENT]  = pres_now;
  assign first_sources[SEL_GATE]     = gate_now;
  assign first_sources[SEL_CHECK]    = checksum_q;
  assign first_sources[SEL_CHOP]     = chop_q;
  assign second_sources[SEL_ENABLE:SEL_GATE] = second_channel_status;
  assign second_sources[SEL_CHECK]   = ff2_now;
  assign second_sources[SEL_CHOP]    = ff1_now;

  wire first_mon_d  = |(mon_sel_q & first_sources);
  wire second_mon_d = |(mon_sel_q & second_sources);

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      sclk_prev_q  <= 1'b0;
      latch_prev_q <= 1'b0;
      vd_prev_q    <= 1'b0;
      ref_prev_q   <= 1'b0;
    end
    else
    begin
      sclk_prev_q  <= serial_clk;
      latch_prev_q <= latch_in;
      vd_prev_q    <= frame_sync;
      ref_prev_q   <= ref_clk;
    end
  end

  // Settings taken from an accepted frame at the latch falling edge.
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      exp_q         <= RST_EXP;
      mon_sel_q     <= RST_MON_SEL;
      normal_mode_q <= 1'b1;
      chop_code_q   <= RST_CHOP;
      enable_q      <= 1'b0;
      dir_q         <= 1'b0;
      cur_q         <= RST_CUR;
      pcount_q      <= RST_COUNT;
      period_q      <= RST_PERIOD;
      wait_pend_q   <= RST_WAIT;
      mag_pend_q    <= RST_WAIT;
    end
    else if (frame_accept)
    begin
      exp_q         <= {b_chop[EXPANDER_OUT_ONE_BIT], b_chop[EXPANDER_OUT_ZERO_BIT]};
      mon_sel_q     <= b_mon[MON_SEL_W-1:0];
      normal_mode_q <= b_mon[POWER_BIT];
      chop_code_q   <= b_chop[CHOP_LSB +: CHOP_W];
      enable_q      <= b_drive[ENABLE_BIT];
      dir_q         <= b_drive[DIR_BIT];
      cur_q         <= cur_clamp;
      pcount_q      <= b_count;
      wait_pend_q   <= b_first;
      mag_pend_q    <= b_mag;
      if (period_valid)
      begin
        period_q <= b_period;
      end
    end
  end

  // Every latch reports the checksum, whether or not the frame is taken.
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      checksum_q <= 1'b1;
    end
    else if (latch_fall)
    begin
      checksum_q <= frame_good;
    end
  end

  // Bridge stays off after a power save until the first wait next ends in normal mode.
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      ps_hold_q <= 1'b0;
    end
    else if (!normal_mode_q)
    begin
      ps_hold_q <= 1'b1;
    end
    else if (ff1_fall)
    begin
      ps_hold_q <= 1'b0;
    end
  end

  // The divider toggles every code reference ticks; it only approximates the real table.
  always_ff @(posedge mclk)
  begin
    if (!reset_n || !chop_run)
    begin
      chop_cnt_q <= 6'h00;
      chop_q     <= 1'b0;
    end
    else if (ref_tick)
    begin
      chop_cnt_q <= chop_wrap ? 6'h00 : chop_cnt_q + CHOP_ONE;
      chop_q     <= chop_wrap ? !chop_q : chop_q;
    end
  end

  always_comb
  begin
    phase_d    = phase_q;
    wait_cnt_d = wait_cnt_q;
    per_cnt_d  = per_cnt_q;
    remain_d   = remain_q;
    step_d     = step_q && !ref_tick;
    ff1_fall   = 1'b0;
    if (vd_rise)
    begin
      step_d = 1'b0;
      if (!normal_mode_q)
      begin
        phase_d = PH_SAVE;
      end
      else
      begin
        phase_d    = PH_FIRST;
        wait_cnt_d = {wait_pend_q, WAIT_PAD};
      end
    end
    else if (ref_tick)
    begin
      unique case (phase_q)
        PH_IDLE, PH_SAVE:
        begin
          phase_d = phase_q;
        end
        PH_FIRST:
        begin
          if (wait_cnt_q == WAIT_ONE)
          begin
            phase_d    = PH_MAG;
            wait_cnt_d = {mag_pend_q, WAIT_PAD};
            ff1_fall   = 1'b1;
          end
          else
          begin
            wait_cnt_d = wait_cnt_q - WAIT_ONE;
          end
        end
        PH_MAG:
        begin
          if (wait_cnt_q != WAIT_ONE)
          begin
            wait_cnt_d = wait_cnt_q - WAIT_ONE;
          end
          else if (checksum_q && pres_now)
          begin
            phase_d   = PH_PULSE;
            remain_d  = {pcount_q, PULSE_PAD};
            per_cnt_d = period_q;
          end
          else
          begin
            phase_d = PH_IDLE;
          end
        end
        PH_PULSE:
        begin
          if (!checksum_q)
          begin
            phase_d = PH_IDLE;
          end
          else if (per_cnt_q == PERIOD_ONE)
          begin
            step_d    = 1'b1;
            per_cnt_d = period_q;
            remain_d  = remain_q - PULSE_ONE;
            if (remain_q == PULSE_ONE)
            begin
              phase_d = PH_IDLE;
            end
          end
          else
          begin
            per_cnt_d = per_cnt_q - PERIOD_ONE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      phase_q    <= PH_IDLE;
      wait_cnt_q <= '0;
      per_cnt_q  <= '0;
      remain_q   <= '0;
      step_q     <= 1'b0;
    end
    else
    begin
      phase_q    <= phase_d;
      wait_cnt_q <= wait_cnt_d;
      per_cnt_q  <= per_cnt_d;
      remain_q   <= remain_d;
      step_q     <= step_d;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      expander_out_zero         <= 1'b0;
      expander_out_zero_oe      <= 1'b0;
      expander_out_one          <= 1'b0;
      expander_out_one_oe       <= 1'b0;
      first_channel_monitor     <= 1'b0;
      second_channel_monitor    <= 1'b0;
      first_channel_step        <= 1'b0;
      first_channel_dir         <= 1'b0;
      first_channel_bridge_on   <= 1'b0;
      current_reference_setting <= RST_CUR;
      chop_frequency_code       <= RST_CHOP;
      chop_wave                 <= 1'b0;
      power_save                <= 1'b0;
      checksum_status           <= 1'b1;
      first_wait_flag           <= 1'b0;
      combined_wait_flag        <= 1'b0;
      pulse_gate_flag           <= 1'b0;
      pulse_present_flag        <= 1'b0;
    end
    else
    begin
      expander_out_zero         <= 1'b0;
      expander_out_zero_oe      <= !exp_q[0];
      expander_out_one          <= 1'b0;
      expander_out_one_oe       <= !exp_q[1];
      first_channel_monitor     <= first_mon_d;
      second_channel_monitor    <= second_mon_d;
      first_channel_step        <= step_q && bridge_now;
      first_channel_dir         <= dir_q;
      first_channel_bridge_on   <= bridge_now;
      current_reference_setting <= cur_q;
      chop_frequency_code       <= chop_code_q;
      chop_wave                 <= chop_q;
      power_save                <= !normal_mode_q;
      checksum_status           <= checksum_q;
      first_wait_flag           <= ff1_now;
      combined_wait_flag        <= ff2_now;
      pulse_gate_flag           <= gate_now;
      pulse_present_flag        <= pres_now;
    end
  end

endmodule : stepper_serial_setup_decoder
`default_nettype wire

// file: setup_decoder_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module setup_decoder_monitor
  import stepper_setup_pkg::*;
(
  input wire logic             mclk,
  input wire logic             reset_n,
  input wire logic             frame_sync,
  input wire logic             latch_in,
  input wire logic             expander_out_zero,
  input wire logic             expander_out_one,
  input wire logic             expander_out_zero_oe,
  input wire logic             expander_out_one_oe,
  input wire logic             first_channel_step,
  input wire logic             first_channel_dir,
  input wire logic             first_channel_bridge_on,
  input wire logic [CUR_W-1:0] current_reference_setting,
  input wire logic             checksum_status,
  input wire logic             first_wait_flag,
  input wire logic             combined_wait_flag,
  input wire logic             pulse_gate_flag
);
  default clocking dcb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence vd_rise_s;
    $rose(frame_sync) ##2 1'b1;
  endsequence

  // Settings may move only one or two edges after a seen latch fall.
  sequence latch_fell_s;
    ($past(latch_in, 2) && !$past(latch_in)) || ($past(latch_in, 3) && !$past(latch_in, 2));
  endsequence

  exp_low_a: assert property (!expander_out_zero && !expander_out_one)
    else $error("expander data pin driven high");
  cur_clamp_a: assert property (current_reference_setting >= CUR_MIN_VALID)
    else $error("current code below lowest valid setting");
  wait_nest_a: assert property ($fell(first_wait_flag) |-> combined_wait_flag)
    else $error("combined wait flag low as first wait ends");
  gate_wait_a: assert property (pulse_gate_flag |-> !combined_wait_flag)
    else $error("pulse gate open during wait interval");
  step_gate_a: assert property ($rose(first_channel_step) |-> pulse_gate_flag)
    else $error("step pulse outside pulse gate");
  step_bridge_a: assert property ($rose(first_channel_step) |-> first_channel_bridge_on)
    else $error("step pulse with bridge off");
  hold_set_a: assert property ($changed({expander_out_zero_oe, expander_out_one_oe,
    first_channel_dir, current_reference_setting, checksum_status}) |-> latch_fell_s)
    else $error("setting changed without latch");
  vd_start_a: assert property (vd_rise_s |-> first_wait_flag)
    else $error("first wait flag not raised after frame sync");
endmodule : setup_decoder_monitor

bind stepper_serial_setup_decoder setup_decoder_monitor monitor_inst (.mclk, .reset_n,
  .frame_sync, .latch_in, .expander_out_zero, .expander_out_one, .expander_out_zero_oe,
  .expander_out_one_oe, .first_channel_step, .first_channel_dir, .first_channel_bridge_on,
  .current_reference_setting, .checksum_status, .first_wait_flag, .combined_wait_flag,
  .pulse_gate_flag);
`default_nettype wire

// file: host_frame_sender.sv
`timescale 1ns/1ps
`default_nettype none
module host_frame_sender (
  input  wire logic mclk,
  output logic      serial_clk,
  output logic      serial_data,
  output logic      latch_in
);
  initial
  begin
    serial_clk = 1'h0;
    serial_data = 1'h0;
    latch_in = 1'h0;
  end

  task automatic send_frame(input logic [103:0] frame);
    for (int i = 0; i < 104; i++)
    begin
      @(negedge mclk);
      serial_clk = 1'h0;
      serial_data = frame[i];
      repeat (2) @(negedge mclk);
      serial_clk = 1'h1;
      @(negedge mclk);
    end
    // A released data line must not keep looking like the last bit.
    serial_data = ~serial_data;
  endtask : send_frame

  task automatic latch_frame();
    @(negedge mclk);
    latch_in = 1'h1;
    repeat (2) @(negedge mclk);
    latch_in = 1'h0;
    repeat (2) @(negedge mclk);
  endtask : latch_frame
endmodule : host_frame_sender
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import stepper_setup_pkg::*;
;
  logic mclk = 1'h0, reset_n = 1'h0, ref_clk = 1'h0, frame_sync = 1'h0;
  logic [4:0] second_channel_status = 5'h00;
  logic serial_clk, serial_data, latch_in, expander_out_zero, expander_out_zero_oe;
  logic expander_out_one, expander_out_one_oe, first_channel_monitor, second_channel_monitor;
  logic first_channel_step, first_channel_dir, first_channel_bridge_on, chop_wave, power_save;
  logic checksum_status, first_wait_flag, combined_wait_flag, pulse_gate_flag;
  logic pulse_present_flag;
  logic [CUR_W-1:0] current_reference_setting;
  logic [CHOP_W-1:0] chop_frequency_code;
  int bad_count = 0;
  int checked = 0;

  initial forever #50 mclk = ~mclk;
  always @(negedge mclk) ref_clk <= ~ref_clk;

  host_frame_sender host_frame_sender_inst (.mclk, .serial_clk, .serial_data, .latch_in);
  stepper_serial_setup_decoder stepper_serial_setup_decoder_inst (.mclk, .reset_n,
    .serial_clk, .serial_data, .latch_in, .frame_sync, .ref_clk, .second_channel_status,
    .expander_out_zero, .expander_out_zero_oe, .expander_out_one, .expander_out_one_oe,
    .first_channel_monitor, .second_channel_monitor, .first_channel_step, .first_channel_dir,
    .first_channel_bridge_on, .current_reference_setting, .chop_frequency_code, .chop_wave,
    .power_save, .checksum_status, .first_wait_flag, .combined_wait_flag, .pulse_gate_flag,
    .pulse_present_flag);

  task automatic summarize();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic await(ref logic sig, input logic lvl, input int lim, output int n);
    n = 0;
    while (sig !== lvl && n < lim)
    begin
      @(negedge mclk);
      n++;
    end
    if (n == lim)
    begin
      bad_count++;
      summarize();
    end
  endtask : await

  // Bytes one to eight come in b, byte one lowest; the checksum is made so the sum is skew.
  task automatic load(input logic [63:0] b, input logic [7:0] skew, input bit do_latch = 1);
    logic [7:0] s;
    s = skew;
    for (int i = 0; i < 8; i++)
      s = s - b[8*i +: 8];
    host_frame_sender_inst.send_frame({s, 32'h0, b});
    if (do_latch)
      host_frame_sender_inst.latch_frame();
    repeat (3) @(negedge mclk);
  endtask : load

  task automatic settings_case();
    int c;
    logic prev;
    load({8'h00, 8'h03, 8'h00, 8'h75, 8'he0, 8'h85, 8'h01, 8'h01}, 8'h00, 0);
    check(expander_out_zero_oe, 1'h0);
    host_frame_sender_inst.latch_frame();
    repeat (3) @(negedge mclk);
    check({expander_out_zero_oe, expander_out_one_oe}, 2'h2);
    check(chop_frequency_code, 6'h05);
    check(first_channel_dir, 1'h1);
    check(first_channel_bridge_on, 1'h0);
    check(current_reference_setting, 5'h15);
    check(power_save, 1'h0);
    check(first_channel_monitor, 1'h1);
    second_channel_status = 5'h10;
    repeat (3) @(negedge mclk);
    check(second_channel_monitor, 1'h1);
    second_channel_status = 5'h00;
    repeat (3) @(negedge mclk);
    check(second_channel_monitor, 1'h0);
    // Code 5 toggles the chop wave every 5 ticks, so a 40-cycle window holds 4 toggles.
    c = 0;
    for (int t = 0; t < 40; t++)
    begin
      prev = chop_wave;
      @(negedge mclk);
      c += int'(chop_wave != prev);
    end
    check(c, 4);
  endtask : settings_case

  task automatic clamp_case();
    logic [4:0] code [4] = '{5'h00, 5'h0a, 5'h0b, 5'h1f};
    for (int i = 0; i < 4; i++)
    begin
      load({8'h00, 8'h01, 8'h01, 3'h0, code[i], 8'h80, 8'hc0, 8'h01, 8'h01}, 8'h00);
      check(current_reference_setting, code[i] > CUR_CLAMP_MAX ? code[i] : CUR_MIN_VALID);
    end
  endtask : clamp_case

  task automatic reject_case();
    load({8'h00, 8'h01, 8'h01, 8'h10, 8'h80, 8'hc0, 8'h01, 8'h01}, 8'h01);
    check(checksum_status, 1'h0);
    check(current_reference_setting, 5'h1f);
    load({8'h00, 8'h01, 8'h01, 8'h10, 8'h80, 8'hc0, 8'h00, 8'h01}, 8'h00);
    check(current_reference_setting, 5'h1f);
    check(checksum_status, 1'h1);
  endtask : reject_case

  task automatic timing_case();
    int n, c, t, first;
    logic prev;
    load({8'h00, 8'h03, 8'h01, 8'h90, 8'h82, 8'hc0, 8'h01, 8'h01}, 8'h00);
    frame_sync = 1'h1;
    await(first_wait_flag, 1'h1, 20, n);
    await(first_wait_flag, 1'h0, 5000, n);
    check(n, 2048);
    check(second_channel_monitor, 1'h1);
    await(combined_wait_flag, 1'h0, 5000, n);
    check(n, 2048);
    c = 0;
    first = 0;
    for (t = 0; t < 200; t++)
    begin
      prev = first_channel_step;
      @(negedge mclk);
      if (t == 10)
        check({pulse_present_flag, first_channel_bridge_on}, 2'h3);
      if (first_channel_step && !prev)
      begin
        c++;
        if (c == 1)
          first = t;
        if (c == 2)
          check(t - first, 6);
      end
    end
    check(c, 4);
    check(pulse_gate_flag, 1'h0);
    check(second_channel_monitor, 1'h0);
  endtask : timing_case

  task automatic save_case();
    load({8'h00, 8'h03, 8'h00, 8'h90, 8'h00, 8'hc0, 8'h01, 8'h01}, 8'h00);
    check({power_save, first_channel_bridge_on}, 2'h2);
    frame_sync = 1'h0;
    repeat (3) @(negedge mclk);
    frame_sync = 1'h1;
    repeat (4) @(negedge mclk);
    check({first_wait_flag, combined_wait_flag}, 2'h2);
  endtask : save_case

  initial
  begin
    repeat (16) @(negedge mclk);
    reset_n = 1'h1;
    repeat (2) @(negedge mclk);
    check({checksum_status, current_reference_setting}, 6'h2b);
    check({expander_out_zero_oe, expander_out_one_oe, chop_frequency_code}, 8'h00);
    settings_case();
    clamp_case();
    reject_case();
    timing_case();
    save_case();
    summarize();
  end

  initial
  begin
    repeat (100000) @(posedge mclk);
    bad_count++;
    summarize();
  end
endmodule : tb_top
`default_nettype wire
